// file: logic/tlsa_top.sv
// round-robin limit checker with sticky status and two alert outputs
// Notes on behaviour
// - channels converted in turn; each out-of-limit result sets its flag
// - high check faults when value is at or above high bound
// - low check faults only when value is below low bound
// - all temperature and timer-percent bounds are 8-bit host-writable
// - monitoring runs from reset; restarts when enable bit written 1
// - writing 0 to enable bit halts the cycle until set again
// - each result lands in its channel value register on completion
// - local conversion takes 11 ms, remote 32 ms
// - a new cycle follows immediately while monitoring stays enabled
// - fan conditions run independently of the temperature sequence
// - status bits read 1 out of limit; status at 0x4f to 0x51
// - flags stick; clear on read or alert response once back in limit
// - status 3 bit 0 reads 1 while bus alert line is driven low
// - latched bus alert goes low for any unmasked out-of-limit flag
// - comparator alert follows live unmasked conditions other than pin active, self-releasing
// - masks at 0x08..0x0a block alerts but flags still set
// - status 1 bits 7..3: local/remote high/low, remote diode fault
// - status 2 bits 7,6 hard faults, bit 4 timer, bit 3 asserted
// - status 2 bit 2 pin active; read clears only once pin inactive
// - status 3 bit 7 fan stall, bit 6 fan alarm speed
// - bus alert stays low after recovery until read or alert response
// - mask bit 1 suppresses alert for its source, 0 allows it
`timescale 1ns/1ps
module tlsa_top #(
  parameter int unsigned LOCAL_CONV_CYCLES =
    tlsa_pkg::TLSA_LOCAL_CONV_CYCLES,
  parameter int unsigned REMOTE_CONV_CYCLES =
    tlsa_pkg::TLSA_REMOTE_CONV_CYCLES
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // register port from the bus engine
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  input wire logic i_ara_done,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // measurement front end
  output logic o_conv_start,
  output logic o_conv_remote,
  input wire logic [7:0] i_conv_result,
  input wire logic i_diode_fault,
  // hard-limit pin and timer conditions
  input wire logic i_hard_out_asserted,
  input wire logic i_hard_pin_active,
  input wire logic i_hard_timer_over,
  // fan conditions
  input wire logic i_fan_stall,
  input wire logic i_fan_alarm,
  // open-drain alert pins
  output logic o_bus_alert_o,
  output logic o_bus_alert_oe,
  output logic o_comp_alert_o,
  output logic o_comp_alert_oe,
  // sequencer state
  output logic o_monitoring
);
  import tlsa_pkg::*;

  typedef struct packed {
    tlsa_seq_t seq;
    logic chan;
    logic [TLSA_TIMER_W-1:0] timer;
    logic mon_en;
    logic [7:0] mask1;
    logic [7:0] mask2;
    logic [7:0] mask3;
    logic [7:0] local_high_bound;
    logic [7:0] local_low_bound;
    logic [7:0] local_hard_bound;
    logic [7:0] remote_high_bound;
    logic [7:0] remote_low_bound;
    logic [7:0] remote_hard_bound;
    logic [7:0] hard_timer_percent_bound;
    logic [7:0] local_value;
    logic [7:0] remote_value;
    logic [7:0] cond1;
    logic local_hard_cond;
    logic remote_hard_cond;
    logic [7:0] temperature_fault_flags;
    logic [7:0] hard_limit_fault_flags;
    logic [7:0] fan_flags;
    logic bus_alert;
    logic comp_alert;
    logic [7:0] rdata;
    logic rvalid;
  } tlsa_state_t;

  tlsa_state_t state_reg;
  tlsa_state_t state_next;

  // per-channel bounds and comparison results
  logic [7:0] high_b [TLSA_NUM_CH];
  logic [7:0] low_b [TLSA_NUM_CH];
  logic [7:0] hard_b [TLSA_NUM_CH];
  logic [TLSA_NUM_CH-1:0] over_c;
  logic [TLSA_NUM_CH-1:0] under_c;
  logic [TLSA_NUM_CH-1:0] hard_c;

  assign high_b[TLSA_CH_LOCAL] = state_reg.local_high_bound;
  assign low_b[TLSA_CH_LOCAL] = state_reg.local_low_bound;
  assign hard_b[TLSA_CH_LOCAL] = state_reg.local_hard_bound;
  assign high_b[TLSA_CH_REMOTE] = state_reg.remote_high_bound;
  assign low_b[TLSA_CH_REMOTE] = state_reg.remote_low_bound;
  assign hard_b[TLSA_CH_REMOTE] = state_reg.remote_hard_bound;

  // both channels compare the incoming result; the sequencer picks one
  genvar ch;
  generate
    for (ch = 0; ch < TLSA_NUM_CH; ch++)
    begin : g_cmp
      tlsa_limit_cmp u_cmp (
        .i_value(i_conv_result),
        .i_high(high_b[ch]),
        .i_low(low_b[ch]),
        .i_hard(hard_b[ch]),
        .o_over(over_c[ch]),
        .o_under(under_c[ch]),
        .o_hard(hard_c[ch])
      );
    end
  endgenerate

  // conversion lengths, widened once to the timer width
  localparam logic [TLSA_TIMER_W-1:0] LOCAL_LAST =
    TLSA_TIMER_W'(LOCAL_CONV_CYCLES - 1);
  localparam logic [TLSA_TIMER_W-1:0] REMOTE_LAST =
    TLSA_TIMER_W'(REMOTE_CONV_CYCLES - 1);
  localparam logic [TLSA_TIMER_W-1:0] TIMER_ONE = 20'h00001;
  localparam logic [TLSA_TIMER_W-1:0] TIMER_ZERO = 20'h00000;

  // live condition vectors aligned with the status layouts
  logic [7:0] cond2;
  logic [7:0] cond3;
  logic [7:0] st2_set;
  logic [7:0] st3_set;
  logic [7:0] clr1;
  logic [7:0] clr2;
  logic [7:0] clr3;
  logic conv_last;
  logic wr_hit;
  logic rd1;
  logic rd2;
  logic rd3;

  // condition vectors for status 2 and 3
  always_comb
  begin
    cond2 = TLSA_ZERO8;
    cond2[TLSA_B_LOCAL_HARD] = state_reg.local_hard_cond;
    cond2[TLSA_B_REMOTE_HARD] = state_reg.remote_hard_cond;
    cond2[TLSA_B_TIMER_OVER] = i_hard_timer_over;
    cond2[TLSA_B_HARD_ASSERTED] = (state_reg.local_hard_cond |
      state_reg.remote_hard_cond) & i_hard_out_asserted;
    cond2[TLSA_B_HARD_PIN] = i_hard_pin_active;
    cond3 = TLSA_ZERO8;
    cond3[TLSA_B_FAN_STALL] = i_fan_stall;
    cond3[TLSA_B_FAN_ALARM] = i_fan_alarm;
    st2_set = cond2;
    st3_set = cond3;
  end

  // read strobes and alert response clear their flags, only once back in limit
  always_comb
  begin
    rd1 = i_reg_rd && (i_reg_addr == TLSA_ADDR_STATUS1);
    rd2 = i_reg_rd && (i_reg_addr == TLSA_ADDR_STATUS2);
    rd3 = i_reg_rd && (i_reg_addr == TLSA_ADDR_STATUS3);
    clr1 = {8{rd1 | i_ara_done}} & ~state_reg.cond1;
    clr2 = {8{rd2 | i_ara_done}} & ~cond2;
    clr3 = {8{rd3 | i_ara_done}} & ~cond3;
  end

  // current slot ends on its own length
  assign conv_last = state_reg.chan ?
    (state_reg.timer == REMOTE_LAST) :
    (state_reg.timer == LOCAL_LAST);

  assign wr_hit = i_reg_wr;

  // next-state logic for the whole block
  always_comb
  begin
    state_next = state_reg;
    state_next.rvalid = 1'b0;

    // host writes; status and value registers ignore them
    if (wr_hit)
    begin
      unique case (i_reg_addr)
        TLSA_ADDR_CONFIG:
          state_next.mon_en = i_reg_wdata[TLSA_CFG_MON_BIT];
        TLSA_ADDR_MASK1: state_next.mask1 = i_reg_wdata;
        TLSA_ADDR_MASK2: state_next.mask2 = i_reg_wdata;
        TLSA_ADDR_MASK3: state_next.mask3 = i_reg_wdata;
        TLSA_ADDR_LOCAL_HIGH: state_next.local_high_bound = i_reg_wdata;
        TLSA_ADDR_LOCAL_LOW: state_next.local_low_bound = i_reg_wdata;
        TLSA_ADDR_LOCAL_HARD: state_next.local_hard_bound = i_reg_wdata;
        TLSA_ADDR_REMOTE_HIGH:
          state_next.remote_high_bound = i_reg_wdata;
        TLSA_ADDR_REMOTE_LOW: state_next.remote_low_bound = i_reg_wdata;
        TLSA_ADDR_REMOTE_HARD:
          state_next.remote_hard_bound = i_reg_wdata;
        TLSA_ADDR_TIMER_PCT:
          state_next.hard_timer_percent_bound = i_reg_wdata;
        default: ;
      endcase
    end

    // round-robin sequencer; disable aborts the slot at once
    unique case (state_reg.seq)
      TLSA_IDLE:
      begin
        state_next.timer = TIMER_ZERO;
        if (state_reg.mon_en)
        begin
          state_next.seq = TLSA_CONV;
        end
      end
      TLSA_CONV:
      begin
        if (!state_reg.mon_en)
        begin
          state_next.seq = TLSA_IDLE;
          state_next.timer = TIMER_ZERO;
        end
        else if (conv_last)
        begin
          state_next.timer = TIMER_ZERO;
          state_next.chan = ~state_reg.chan;
          if (state_reg.chan)
          begin
            state_next.remote_value = i_conv_result;
            state_next.cond1[TLSA_B_REMOTE_OVER] = over_c[TLSA_CH_REMOTE];
            state_next.cond1[TLSA_B_REMOTE_UNDER] = under_c[TLSA_CH_REMOTE];
            state_next.cond1[TLSA_B_DIODE] = i_diode_fault;
            state_next.remote_hard_cond = hard_c[TLSA_CH_REMOTE];
          end
          else
          begin
            state_next.local_value = i_conv_result;
            state_next.cond1[TLSA_B_LOCAL_OVER] = over_c[TLSA_CH_LOCAL];
            state_next.cond1[TLSA_B_LOCAL_UNDER] = under_c[TLSA_CH_LOCAL];
            state_next.local_hard_cond = hard_c[TLSA_CH_LOCAL];
          end
        end
        else
        begin
          state_next.timer = state_reg.timer + TIMER_ONE;
        end
      end
    endcase

    // sticky flags: a new condition outweighs a clear in the same cycle
    state_next.temperature_fault_flags =
      state_next.cond1 | (state_reg.temperature_fault_flags & ~clr1);
    state_next.hard_limit_fault_flags =
      st2_set | (state_reg.hard_limit_fault_flags & ~clr2);
    state_next.fan_flags = st3_set | (state_reg.fan_flags & ~clr3);

    // latched alert follows unmasked sticky flags, so it waits for a clear
    state_next.bus_alert =
      |(state_next.temperature_fault_flags & ~state_reg.mask1) |
      |(state_next.hard_limit_fault_flags & ~state_reg.mask2) |
      |(state_next.fan_flags & ~state_reg.mask3);

    // comparator alert follows live conditions; pin-active condition never feeds it
    state_next.comp_alert =
      |(state_next.cond1 & ~state_reg.mask1) |
      |(cond2 & ~state_reg.mask2 & ~(8'h01 << TLSA_B_HARD_PIN)) |
      |(cond3 & ~state_reg.mask3);

    // read data, registered one cycle after the strobe
    if (i_reg_rd)
    begin
      state_next.rvalid = 1'b1;
      unique case (i_reg_addr)
        TLSA_ADDR_CONFIG:
          state_next.rdata = {7'h00, state_reg.mon_en};
        TLSA_ADDR_MASK1: state_next.rdata = state_reg.mask1;
        TLSA_ADDR_MASK2: state_next.rdata = state_reg.mask2;
        TLSA_ADDR_MASK3: state_next.rdata = state_reg.mask3;
        TLSA_ADDR_LOCAL_HIGH: state_next.rdata = state_reg.local_high_bound;
        TLSA_ADDR_LOCAL_LOW: state_next.rdata = state_reg.local_low_bound;
        TLSA_ADDR_LOCAL_HARD: state_next.rdata = state_reg.local_hard_bound;
        TLSA_ADDR_REMOTE_HIGH: state_next.rdata = state_reg.remote_high_bound;
        TLSA_ADDR_REMOTE_LOW: state_next.rdata = state_reg.remote_low_bound;
        TLSA_ADDR_REMOTE_HARD: state_next.rdata = state_reg.remote_hard_bound;
        TLSA_ADDR_TIMER_PCT:
          state_next.rdata = state_reg.hard_timer_percent_bound;
        TLSA_ADDR_LOCAL_VALUE: state_next.rdata = state_reg.local_value;
        TLSA_ADDR_REMOTE_VALUE: state_next.rdata = state_reg.remote_value;
        TLSA_ADDR_STATUS1:
          state_next.rdata = state_reg.temperature_fault_flags;
        TLSA_ADDR_STATUS2:
          state_next.rdata = state_reg.hard_limit_fault_flags;
        TLSA_ADDR_STATUS3:
        begin
          state_next.rdata = state_reg.fan_flags;
          state_next.rdata[TLSA_B_BUS_ALERT] = state_reg.bus_alert;
        end
        default: state_next.rdata = TLSA_ZERO8;
      endcase
    end
  end

  // single register stage; reset loads the documented defaults
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      state_reg <= '0;
      state_reg.seq <= TLSA_IDLE;
      state_reg.mon_en <= 1'b1;
      state_reg.mask1 <= TLSA_RST_MASK;
      state_reg.mask2 <= TLSA_RST_MASK;
      state_reg.mask3 <= TLSA_RST_MASK;
      state_reg.local_high_bound <= TLSA_RST_HIGH;
      state_reg.local_low_bound <= TLSA_RST_LOW;
      state_reg.local_hard_bound <= TLSA_RST_HARD;
      state_reg.remote_high_bound <= TLSA_RST_HIGH;
      state_reg.remote_low_bound <= TLSA_RST_LOW;
      state_reg.remote_hard_bound <= TLSA_RST_HARD;
      state_reg.hard_timer_percent_bound <= TLSA_RST_TIMER_PCT;
      state_reg.local_value <= TLSA_RST_VALUE;
      state_reg.remote_value <= TLSA_RST_VALUE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // outputs; reserved status bits are never set so they read 0
  assign o_reg_rdata = state_reg.rdata;
  assign o_reg_rvalid = state_reg.rvalid;
  assign o_conv_start = (state_reg.seq == TLSA_CONV) &&
    (state_reg.timer == TIMER_ZERO) && state_reg.mon_en;
  assign o_conv_remote = state_reg.chan;
  assign o_monitoring = (state_reg.seq == TLSA_CONV);
  // open-drain pins only ever pull low
  assign o_bus_alert_o = 1'b0;
  assign o_bus_alert_oe = state_reg.bus_alert;
  assign o_comp_alert_o = 1'b0;
  assign o_comp_alert_oe = state_reg.comp_alert;

endmodule

// file: logic/tlsa_pkg.sv
// shared constants for the temperature limit, status and alert block
package tlsa_pkg;

  // register offsets
  localparam logic [7:0] TLSA_ADDR_CONFIG = 8'h01;
  localparam logic [7:0] TLSA_ADDR_MASK1 = 8'h08;
  localparam logic [7:0] TLSA_ADDR_MASK2 = 8'h09;
  localparam logic [7:0] TLSA_ADDR_MASK3 = 8'h0a;
  localparam logic [7:0] TLSA_ADDR_LOCAL_HIGH = 8'h0b;
  localparam logic [7:0] TLSA_ADDR_LOCAL_LOW = 8'h0c;
  localparam logic [7:0] TLSA_ADDR_LOCAL_HARD = 8'h0d;
  localparam logic [7:0] TLSA_ADDR_REMOTE_HIGH = 8'h0e;
  localparam logic [7:0] TLSA_ADDR_REMOTE_LOW = 8'h0f;
  localparam logic [7:0] TLSA_ADDR_REMOTE_HARD = 8'h10;
  localparam logic [7:0] TLSA_ADDR_TIMER_PCT = 8'h19;
  localparam logic [7:0] TLSA_ADDR_LOCAL_VALUE = 8'h41;
  localparam logic [7:0] TLSA_ADDR_REMOTE_VALUE = 8'h43;
  localparam logic [7:0] TLSA_ADDR_STATUS1 = 8'h4f;
  localparam logic [7:0] TLSA_ADDR_STATUS2 = 8'h50;
  localparam logic [7:0] TLSA_ADDR_STATUS3 = 8'h51;

  // reset values
  localparam logic [7:0] TLSA_RST_HIGH = 8'h8b;
  localparam logic [7:0] TLSA_RST_LOW = 8'h54;
  localparam logic [7:0] TLSA_RST_HARD = 8'h95;
  localparam logic [7:0] TLSA_RST_TIMER_PCT = 8'hff;
  localparam logic [7:0] TLSA_RST_MASK = 8'h00;
  localparam logic [7:0] TLSA_RST_VALUE = 8'h00;
  localparam logic [7:0] TLSA_ZERO8 = 8'h00;

  // configuration field
  localparam int TLSA_CFG_MON_BIT = 0;

  // status 1 / mask 1 bit positions
  localparam int TLSA_B_LOCAL_OVER = 7;
  localparam int TLSA_B_LOCAL_UNDER = 6;
  localparam int TLSA_B_REMOTE_OVER = 5;
  localparam int TLSA_B_REMOTE_UNDER = 4;
  localparam int TLSA_B_DIODE = 3;
  // status 2 / mask 2 bit positions
  localparam int TLSA_B_LOCAL_HARD = 7;
  localparam int TLSA_B_REMOTE_HARD = 6;
  localparam int TLSA_B_TIMER_OVER = 4;
  localparam int TLSA_B_HARD_ASSERTED = 3;
  localparam int TLSA_B_HARD_PIN = 2;
  // status 3 / mask 3 bit positions
  localparam int TLSA_B_FAN_STALL = 7;
  localparam int TLSA_B_FAN_ALARM = 6;
  localparam int TLSA_B_BUS_ALERT = 0;

  // conversion timing
  localparam longint TLSA_CLK_HZ = 20000000;
  localparam longint TLSA_LOCAL_CONV_MS = 11;
  localparam longint TLSA_REMOTE_CONV_MS = 32;
  localparam int unsigned TLSA_LOCAL_CONV_CYCLES =
    int'(TLSA_LOCAL_CONV_MS * TLSA_CLK_HZ / 1000);
  localparam int unsigned TLSA_REMOTE_CONV_CYCLES =
    int'(TLSA_REMOTE_CONV_MS * TLSA_CLK_HZ / 1000);
  localparam int TLSA_TIMER_W = 20;
  localparam int TLSA_NUM_CH = 2;
  localparam int TLSA_CH_LOCAL = 0;
  localparam int TLSA_CH_REMOTE = 1;

  // sequencer states
  typedef enum logic {
    TLSA_IDLE,
    TLSA_CONV
  } tlsa_seq_t;

endpackage

// file: logic/tlsa_limit_cmp.sv
// one channel's high, low and hard-limit comparison
`timescale 1ns/1ps
module tlsa_limit_cmp (
  // measured value and its bounds
  input wire logic [7:0] i_value,
  input wire logic [7:0] i_high,
  input wire logic [7:0] i_low,
  input wire logic [7:0] i_hard,
  // comparison results
  output logic o_over,
  output logic o_under,
  output logic o_hard
);

  // high side is inclusive, low side strict
  always_comb
  begin
    o_over = (i_value >= i_high);
    o_under = (i_value < i_low);
    o_hard = (i_value >= i_hard);
  end

endmodule

// file: testbench/tlsa_top_asserts.sv
// concurrent checks on the limit, status and alert block ports
`timescale 1ns/1ps
module tlsa_top_asserts #(
  parameter int unsigned LOCAL_CONV_CYCLES = 8,
  parameter int unsigned REMOTE_CONV_CYCLES = 16
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  input wire logic i_ara_done,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  // sequencer, fan and alerts
  input wire logic o_conv_start,
  input wire logic o_conv_remote,
  input wire logic i_fan_stall,
  input wire logic o_bus_alert_o,
  input wire logic o_bus_alert_oe,
  input wire logic o_comp_alert_o,
  input wire logic o_comp_alert_oe,
  input wire logic o_monitoring
);
  localparam int LC = LOCAL_CONV_CYCLES;
  localparam int RC = REMOTE_CONV_CYCLES;
  logic stall_mask_reg;
  logic halted_reg;
  logic cfg_wr;
  logic quiet;
  assign cfg_wr = i_reg_wr && i_reg_addr == 8'h01;
  // nothing that may lower the latched alert this cycle or the last
  assign quiet = !i_reg_rd && !i_ara_done && !i_reg_wr;
  // mirror the stall mask; slot timing is unchecked while halted
  always_ff @(posedge i_ref_clk)
    if (i_rst)
    begin
      stall_mask_reg <= 1'b0;
      halted_reg <= 1'b0;
    end
    else
    begin
      if (i_reg_wr && i_reg_addr == 8'h0a)
        stall_mask_reg <= i_reg_wdata[7];
      if (cfg_wr)
        halted_reg <= !i_reg_wdata[0];
    end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  rd_answer_a: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read strobe got no answer");
  answer_cause_a: assert property (o_reg_rvalid |-> $past(i_reg_rd))
    else $error("read answer without strobe");
  alert_bit_a: assert property (o_reg_rvalid &&
    $past(i_reg_addr) == 8'h51 |-> o_reg_rdata[0] == $past(o_bus_alert_oe))
    else $error("alert status bit differs from pin");
  reserved_zero_a: assert property (o_reg_rvalid |->
    !($past(i_reg_addr) == 8'h4f && o_reg_rdata[2:0] != 3'h0) &&
    !($past(i_reg_addr) == 8'h50 && (o_reg_rdata & 8'h23) != 8'h00) &&
    !($past(i_reg_addr) == 8'h51 && o_reg_rdata[5:1] != 5'h00))
    else $error("reserved status bit set");
  stall_flag_a: assert property (o_reg_rvalid &&
    $past(i_reg_addr) == 8'h51 && $past(i_fan_stall, 2) |-> o_reg_rdata[7])
    else $error("stall flag missing");
  comp_alert_a: assert property (!$past(i_rst) &&
    $past(i_fan_stall) && !$past(stall_mask_reg) |-> o_comp_alert_oe)
    else $error("comparator alert missing");
  bus_alert_a: assert property (!$past(i_rst) &&
    $past(i_fan_stall) && !$past(stall_mask_reg) |-> o_bus_alert_oe)
    else $error("bus alert missing");
  alert_hold_a: assert property (o_bus_alert_oe && quiet &&
    $past(quiet) |=> o_bus_alert_oe)
    else $error("bus alert released by itself");
  local_slot_a: assert property (disable iff (i_rst || halted_reg)
    o_conv_start && !o_conv_remote |-> ##LC o_conv_start && o_conv_remote)
    else $error("local slot length wrong");
  remote_slot_a: assert property (disable iff (i_rst || halted_reg)
    o_conv_start && o_conv_remote |-> ##RC o_conv_start && !o_conv_remote)
    else $error("remote slot length wrong");
  halt_seq_a: assert property (cfg_wr && !i_reg_wdata[0] |->
    ##[1:3] !o_monitoring)
    else $error("monitoring did not stop");
  // open-drain alert pins may only ever pull low
  pin_drive_a: assert property (!o_bus_alert_o && !o_comp_alert_o)
    else $error("alert pin drives high");
  cover property (o_bus_alert_oe && !o_comp_alert_oe);
  cover property (i_ara_done && o_bus_alert_oe);
  cover property (cfg_wr && i_reg_wdata[0] && !o_monitoring);
endmodule

// file: testbench/tlsa_front_model.sv
// behavioural measurement front end answering conversion slots
`timescale 1ns/1ps
module tlsa_front_model (
  // slot control from the block
  input wire logic i_busy,
  input wire logic i_remote,
  // temperatures to report
  input wire logic [7:0] i_local_val,
  input wire logic [7:0] i_remote_val,
  input wire logic i_diode_bad,
  // results to the block
  output logic [7:0] o_result,
  output logic o_diode_fault
);
  // outside a slot the result is inverted so no stale value looks valid
  always_comb
  begin
    if (!i_busy)
      o_result = ~i_local_val;
    else if (i_remote)
      o_result = i_remote_val;
    else
      o_result = i_local_val;
    o_diode_fault = i_busy & i_remote & i_diode_bad;
  end
endmodule

// file: testbench/tlsa_top_test.sv
// self-checking bench for the limit, status and alert block
`timescale 1ns/1ps
module tlsa_top_test;
  import tlsa_pkg::*;
  localparam int LIMIT = 20000;
  logic i_ref_clk = 0;
  logic i_rst = 1;
  logic [7:0] i_reg_addr = 8'h00;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_reg_wr = 0;
  logic i_reg_rd = 0;
  logic i_ara_done = 0;
  logic i_hard_out_asserted = 0;
  logic i_hard_pin_active = 0;
  logic i_hard_timer_over = 0;
  logic i_fan_stall = 0;
  logic i_fan_alarm = 0;
  logic [7:0] lv = 8'h60;
  logic [7:0] rv = 8'h60;
  logic diode = 0;
  logic [7:0] o_reg_rdata, i_conv_result;
  logic o_reg_rvalid, o_conv_start, o_conv_remote, o_monitoring;
  logic o_bus_alert_oe, o_comp_alert_oe, i_diode_fault;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;
  // short slots keep the run brief
  tlsa_top #(.LOCAL_CONV_CYCLES(8), .REMOTE_CONV_CYCLES(16)) dut (
    .o_bus_alert_o(), .o_comp_alert_o(), .*);
  tlsa_front_model fe (.i_busy(o_monitoring), .i_remote(o_conv_remote),
    .i_local_val(lv), .i_remote_val(rv), .i_diode_bad(diode),
    .o_result(i_conv_result), .o_diode_fault(i_diode_fault));
  always #25 i_ref_clk = ~i_ref_clk;
  // hang guard
  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chb(input logic b, input logic e);
    chk({7'h00, b}, {7'h00, e});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask
  // one strobe cycle per access, inputs moved on the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    i_reg_wr = 1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_ref_clk);
    i_reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_ref_clk);
    i_reg_rd = 1;
    i_reg_addr = a;
    @(negedge i_ref_clk);
    i_reg_rd = 0;
    chb(o_reg_rvalid, 1'b1);
    d = o_reg_rdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  // a full round plus margin, then drop every cleared flag
  task automatic clear();
    logic [7:0] d;
    cyc(30);
    rd(8'h4f, d);
    rd(8'h50, d);
    rd(8'h51, d);
  endtask
  task automatic t_defaults();
    logic [7:0] a [10] = '{8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10,
      8'h19, 8'h08, 8'h09, 8'h0a};
    logic [7:0] v [10] = '{8'h8b, 8'h54, 8'h95, 8'h8b, 8'h54, 8'h95,
      8'hff, 8'h00, 8'h00, 8'h00};
    for (int k = 0; k < 10; k++)
      rdc(a[k], v[k]);
    for (int k = 0; k < 10; k++)
    begin
      wr(a[k], 8'h5a ^ 8'(k));
      rdc(a[k], 8'h5a ^ 8'(k));
      wr(a[k], v[k]);
    end
    rdc(8'h01, 8'h01);
    rdc(8'h7e, 8'h00);
    $display("test defaults done");
  endtask
  task automatic t_limits();
    lv = 8'h8b;
    rv = 8'h54;
    cyc(30);
    rdc(8'h41, 8'h8b);
    rdc(8'h43, 8'h54);
    chb(o_comp_alert_oe, 1'b1);
    chb(o_bus_alert_oe, 1'b1);
    rdc(8'h4f, 8'h80);
    lv = 8'h8a;
    rv = 8'h60;
    cyc(30);
    chb(o_comp_alert_oe, 1'b0);
    chb(o_bus_alert_oe, 1'b1);
    rdc(8'h51, 8'h01);
    rdc(8'h4f, 8'h80);
    rdc(8'h4f, 8'h00);
    cyc(3);
    chb(o_bus_alert_oe, 1'b0);
    rv = 8'h53;
    cyc(30);
    rdc(8'h4f, 8'h10);
    rv = 8'h60;
    diode = 1;
    cyc(30);
    rdc(8'h4f, 8'h18);
    diode = 0;
    cyc(30);
    rdc(8'h4f, 8'h08);
    rdc(8'h4f, 8'h00);
    $display("test limits done");
  endtask
  task automatic t_hard();
    lv = 8'h95;
    i_hard_out_asserted = 1;
    i_hard_timer_over = 1;
    i_hard_pin_active = 1;
    cyc(30);
    rdc(8'h50, 8'h9c);
    lv = 8'h60;
    i_hard_out_asserted = 0;
    i_hard_timer_over = 0;
    cyc(30);
    rdc(8'h50, 8'h9c);
    rdc(8'h50, 8'h04);
    i_hard_pin_active = 0;
    cyc(2);
    rdc(8'h50, 8'h04);
    rdc(8'h50, 8'h00);
    wr(8'h50, 8'hff);
    rdc(8'h50, 8'h00);
    $display("test hard done");
  endtask
  task automatic t_mask();
    wr(8'h0a, 8'h80);
    i_fan_stall = 1;
    cyc(3);
    chb(o_bus_alert_oe, 1'b0);
    chb(o_comp_alert_oe, 1'b0);
    i_fan_stall = 0;
    rdc(8'h51, 8'h80);
    rdc(8'h51, 8'h00);
    wr(8'h0a, 8'h00);
    i_fan_alarm = 1;
    cyc(3);
    chb(o_bus_alert_oe, 1'b1);
    chb(o_comp_alert_oe, 1'b1);
    rdc(8'h51, 8'h41);
    i_fan_alarm = 0;
    cyc(3);
    chb(o_comp_alert_oe, 1'b0);
    chb(o_bus_alert_oe, 1'b1);
    i_ara_done = 1;
    cyc(1);
    i_ara_done = 0;
    cyc(3);
    chb(o_bus_alert_oe, 1'b0);
    rdc(8'h51, 8'h00);
    $display("test mask done");
  endtask
  task automatic t_halt();
    logic [7:0] n;
    logic seen;
    n = 8'h00;
    seen = 0;
    wr(8'h01, 8'h00);
    cyc(4);
    chb(o_monitoring, 1'b0);
    lv = 8'h99;
    repeat (60)
    begin
      @(negedge i_ref_clk);
      n = n + {7'h00, o_conv_start};
    end
    chk(n, 8'h00);
    rdc(8'h41, 8'h60);
    i_fan_stall = 1;
    cyc(2);
    rdc(8'h51, 8'h81);
    i_fan_stall = 0;
    rdc(8'h51, 8'h81);
    wr(8'h01, 8'h01);
    repeat (6)
    begin
      if (o_conv_start === 1'b1)
        seen = 1;
      @(negedge i_ref_clk);
    end
    chb(seen, 1'b1);
    cyc(30);
    rdc(8'h41, 8'h99);
    rdc(8'h01, 8'h01);
    $display("test halt done");
  endtask
  initial
  begin
    cyc(4);
    i_rst = 0;
    t_defaults();
    clear();
    t_limits();
    clear();
    t_hard();
    clear();
    t_mask();
    t_halt();
    report_and_stop();
  end
endmodule
bind tlsa_top tlsa_top_asserts #(.LOCAL_CONV_CYCLES(LOCAL_CONV_CYCLES),
  .REMOTE_CONV_CYCLES(REMOTE_CONV_CYCLES)) u_chk (.*);
